// >>> rtl/lgr_top.v
// GPIO router of a dual-link deserializer hub: pin output selection, forwarded GPIO
// sampling and back-channel slot sampling, with registers over AHB-Lite.
// Assumes link status and forwarded GPIO arrive on mclk_i; pins are asynchronous.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "lgr_map.vh"

module lgr_top #(
  parameter integer PINS = 7,
  parameter integer FRAME_CYCLES = `LGR_BC_FRAME_CYC
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire hsel_i,
  input wire [9:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  input wire [PINS-1:0] gpio_pin_i,
  output wire [PINS-1:0] gpio_pin_o,
  output wire [PINS-1:0] gpio_pin_oe_n_o,
  input wire [3:0] fwd_gpio0_i,
  input wire [3:0] fwd_gpio1_i,
  input wire [1:0] fwd_frame_i,
  input wire [1:0] rx_lock_i,
  input wire [1:0] rx_pass_i,
  input wire [1:0] rx_fv_i,
  input wire [1:0] rx_lv_i,
  input wire csi_fv_i,
  input wire csi_lv_i,
  input wire rx_synced_i,
  input wire dev_irq_i,
  input wire csi_irq_i,
  input wire frame_sync_pulse_i,
  input wire ext_frame_sync_i,
  output reg [3:0] bc_slot0_o,
  output reg [3:0] bc_slot1_o,
  output reg bc_frame_o
);

  // ****************************************************************************
  // Helpers
  // ****************************************************************************
  // Sampling period in forward frames for a count of linked forward GPIO.
  function [2:0] fwd_period;
    input [2:0] cnt;
    begin
      if (cnt <= 3'h1) begin
        fwd_period = 3'h1;
      end else if (cnt == 3'h2) begin
        fwd_period = 3'h2;
      end else begin
        fwd_period = 3'h5;
      end
    end
  endfunction

  // Level for one back-channel slot: codes 0..6 pick a pin, 7 the frame sync.
  function slot_pick;
    input [2:0] sel;
    input [6:0] pins;
    input fs;
    begin
      if (sel == 3'h7) begin
        slot_pick = fs;
      end else begin
        slot_pick = pins[sel];
      end
    end
  endfunction

  // ****************************************************************************
  // Pin and external frame sync synchronisers
  // ****************************************************************************
  reg [PINS-1:0] pin_meta_q;
  reg [PINS-1:0] pin_sync_q;
  reg efs_meta_q;
  reg efs_sync_q;

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pin_meta_q <= {PINS{1'b0}};
      pin_sync_q <= {PINS{1'b0}};
      efs_meta_q <= 1'b0;
      efs_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= gpio_pin_i;
      pin_sync_q <= pin_meta_q;
      efs_meta_q <= ext_frame_sync_i;
      efs_sync_q <= efs_meta_q;
    end
  end

  // ****************************************************************************
  // Registers
  // ****************************************************************************
  reg [7:0] pin_ctl_q [0:PINS-1];
  reg [7:0] slot_lo_q [0:1];
  reg [7:0] slot_hi_q [0:1];
  reg [7:0] cfg_q;
  reg [7:0] fcnt_q;
  reg wr_pend_q;
  reg [7:0] wr_idx_q;
  reg wr_ok_q;
  integer i;
  integer j;

  wire take = hsel_i & htrans_i[1] & hready_i;
  wire [7:0] a_idx = haddr_i[9:2];
  wire a_ok = (haddr_i[1:0] == 2'h0);
  wire port_sel = cfg_q[`LGR_CFG_PORT];
  wire [1:0] rx_en = cfg_q[`LGR_CFG_RXEN];
  wire [7:0] wbyte = hwdata_i[7:0];

  // Zero-wait slave: every transfer completes in its first data-phase cycle.
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
      wr_ok_q <= 1'b0;
    end else begin
      wr_pend_q <= take & hwrite_i;
      wr_idx_q <= a_idx;
      wr_ok_q <= a_ok;
    end
  end

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      for (i = 0; i < PINS; i = i + 1) begin
        pin_ctl_q[i] <= `LGR_PIN_RST;
      end
      slot_lo_q[0] <= `LGR_SLOT_RST;
      slot_lo_q[1] <= `LGR_SLOT_RST;
      slot_hi_q[0] <= `LGR_SLOT_RST;
      slot_hi_q[1] <= `LGR_SLOT_RST;
      cfg_q <= `LGR_CFG_RST;
      fcnt_q <= `LGR_FCNT_RST;
    end else if (wr_pend_q && wr_ok_q) begin
      for (i = 0; i < PINS; i = i + 1) begin
        if (wr_idx_q == `LGR_IDX_PIN0 + i[7:0]) begin
          pin_ctl_q[i] <= wbyte;
        end
      end
      if (wr_idx_q == `LGR_IDX_SLOT_LO) begin
        slot_lo_q[port_sel] <= wbyte;
      end
      if (wr_idx_q == `LGR_IDX_SLOT_HI) begin
        slot_hi_q[port_sel] <= wbyte;
      end
      if (wr_idx_q == `LGR_IDX_CFG) begin
        cfg_q <= {4'h0, wbyte[3:0]};
      end
      if (wr_idx_q == `LGR_IDX_FCNT) begin
        fcnt_q <= {1'b0, wbyte[6:4], 1'b0, wbyte[2:0]};
      end
    end
  end

  // Read data is captured in the address phase so it stands in the data phase.
  reg [7:0] rd_d;
  always @* begin
    rd_d = 8'h00;
    for (j = 0; j < PINS; j = j + 1) begin
      if (a_idx == `LGR_IDX_PIN0 + j[7:0]) begin
        rd_d = pin_ctl_q[j];
      end
    end
    case (a_idx)
      `LGR_IDX_SLOT_LO: rd_d = slot_lo_q[port_sel];
      `LGR_IDX_SLOT_HI: rd_d = slot_hi_q[port_sel];
      `LGR_IDX_CFG: rd_d = cfg_q;
      `LGR_IDX_FCNT: rd_d = fcnt_q;
      `LGR_IDX_STAT: rd_d = {1'b0, pin_sync_q};
      default: ;
    endcase
    if (!a_ok) begin
      rd_d = 8'h00;
    end
  end

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      hrdata_o <= 32'h00000000;
    end else if (take && !hwrite_i) begin
      hrdata_o <= {24'h000000, rd_d};
    end
  end

  // ****************************************************************************
  // Forwarded GPIO sampling
  // ****************************************************************************
  // The hold register updates on the last frame of each sampling period, so the
  // delay from the frame that carries the data stays the same for any count.
  reg [2:0] fcnt0_q;
  reg [2:0] fcnt1_q;
  reg [3:0] fwd0_q;
  reg [3:0] fwd1_q;
  wire [2:0] per0 = fwd_period(fcnt_q[2:0]);
  wire [2:0] per1 = fwd_period(fcnt_q[6:4]);

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fcnt0_q <= 3'h0;
      fcnt1_q <= 3'h0;
      fwd0_q <= 4'h0;
      fwd1_q <= 4'h0;
    end else begin
      if (fwd_frame_i[0]) begin
        if (fcnt0_q + 3'h1 >= per0) begin
          fcnt0_q <= 3'h0;
          fwd0_q <= fwd_gpio0_i;
        end else begin
          fcnt0_q <= fcnt0_q + 3'h1;
        end
      end
      if (fwd_frame_i[1]) begin
        if (fcnt1_q + 3'h1 >= per1) begin
          fcnt1_q <= 3'h0;
          fwd1_q <= fwd_gpio1_i;
        end else begin
          fcnt1_q <= fcnt1_q + 3'h1;
        end
      end
    end
  end

  // ****************************************************************************
  // Pin output selection
  // ****************************************************************************
  wire fs_sel = cfg_q[`LGR_CFG_EXTFS] ? efs_sync_q : frame_sync_pulse_i;
  // Disabled ports count as locked/passing for AND and as absent for OR.
  wire lock_or = |(rx_lock_i & rx_en);
  wire lock_and = &(rx_lock_i | ~rx_en);
  wire pass_and = &(rx_pass_i | ~rx_en);
  wire pass_or = |(rx_pass_i & rx_en);
  wire [7:0] rx0_vec = {rx_lv_i[0], rx_fv_i[0], rx_pass_i[0], rx_lock_i[0], fwd0_q};
  wire [7:0] rx1_vec = {rx_lv_i[1], rx_fv_i[1], rx_pass_i[1], rx_lock_i[1], fwd1_q};
  wire [6:0] dev_vec = {~dev_irq_i, dev_irq_i, fs_sel, pass_and, lock_and, lock_or, 1'b0};
  wire [5:0] csi_vec = {csi_irq_i, rx_synced_i, csi_lv_i, csi_fv_i, pass_or, pass_and};

  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : g_pin
      lgr_pin_mux u_mux (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .src_i(pin_ctl_q[g][`LGR_PIN_SRC]),
        .func_i(pin_ctl_q[g][`LGR_PIN_FUNC]),
        .level_i(pin_ctl_q[g][`LGR_PIN_LEVEL]),
        .drive_i(pin_ctl_q[g][`LGR_PIN_DRIVE]),
        .rx0_i(rx0_vec),
        .rx1_i(rx1_vec),
        .dev_i(dev_vec),
        .csi_i(csi_vec),
        .pin_o(gpio_pin_o[g]),
        .pin_oe_n_o(gpio_pin_oe_n_o[g])
      );
    end
  endgenerate

  // ****************************************************************************
  // Back-channel slot sampling
  // ****************************************************************************
  wire bc_stb;

  lgr_bc_framer #(
    .FRAME_CYCLES(FRAME_CYCLES)
  ) u_framer (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .frame_stb_o(bc_stb)
  );

  // Pins are sampled once per frame; a pin that toggles faster is aliased.
  wire [6:0] pins7 = pin_sync_q[6:0];
  reg [3:0] s0_d;
  reg [3:0] s1_d;
  always @* begin
    s0_d[0] = slot_pick(slot_lo_q[0][2:0], pins7, fs_sel);
    s0_d[1] = slot_pick(slot_lo_q[0][6:4], pins7, fs_sel);
    s0_d[2] = slot_pick(slot_hi_q[0][2:0], pins7, fs_sel);
    s0_d[3] = slot_pick(slot_hi_q[0][6:4], pins7, fs_sel);
    s1_d[0] = slot_pick(slot_lo_q[1][2:0], pins7, fs_sel);
    s1_d[1] = slot_pick(slot_lo_q[1][6:4], pins7, fs_sel);
    s1_d[2] = slot_pick(slot_hi_q[1][2:0], pins7, fs_sel);
    s1_d[3] = slot_pick(slot_hi_q[1][6:4], pins7, fs_sel);
  end

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      bc_slot0_o <= 4'h0;
      bc_slot1_o <= 4'h0;
      bc_frame_o <= 1'b0;
    end else begin
      bc_frame_o <= bc_stb;
      if (bc_stb) begin
        bc_slot0_o <= s0_d;
        bc_slot1_o <= s1_d;
      end
    end
  end

endmodule // lgr_top
`default_nettype wire

// >>> pkg/lgr_map.vh
// Register indices, field positions, reset values and timing counts of the GPIO router.
// Assumes a 200 MHz system clock and a 50 Mbps back channel.
`ifndef LGR_MAP_VH
`define LGR_MAP_VH

// ****************************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************************
`define LGR_IDX_SLOT_LO 8'h6e
`define LGR_IDX_SLOT_HI 8'h6f
`define LGR_IDX_PIN0 8'h10
`define LGR_IDX_CFG 8'h18
`define LGR_IDX_FCNT 8'h19
`define LGR_IDX_STAT 8'h1a

// ****************************************************************************
// Pin control fields
// ****************************************************************************
`define LGR_PIN_SRC 2:0
`define LGR_PIN_FUNC 5:3
`define LGR_PIN_LEVEL 6
`define LGR_PIN_DRIVE 7
`define LGR_PIN_RST 8'h00

// ****************************************************************************
// Configuration fields
// ****************************************************************************
`define LGR_CFG_PORT 0
`define LGR_CFG_RXEN 2:1
`define LGR_CFG_EXTFS 3
`define LGR_CFG_RST 8'h06
`define LGR_SLOT_RST 8'h00
`define LGR_FCNT_RST 8'h00

// ****************************************************************************
// Source select codes
// ****************************************************************************
`define LGR_SRC_RX0 3'h0
`define LGR_SRC_RX1 3'h1
`define LGR_SRC_DEV 3'h4
`define LGR_SRC_CSI 3'h5

// ****************************************************************************
// Timing
// ****************************************************************************
`define LGR_CLK_PS 5000
`define LGR_BC_BIT_PS 20000
`define LGR_BC_FRAME_BITS 30
`define LGR_BC_FRAME_CYC (`LGR_BC_FRAME_BITS * `LGR_BC_BIT_PS / `LGR_CLK_PS)
`define LGR_FWD_LAT_PS 225000

`endif

// >>> rtl/lgr_bc_framer.v
// Back-channel frame timer: one pulse per back-channel frame.
// Assumes one clock; the frame length is a whole number of cycles.
`timescale 1ns/1ps
`default_nettype none
module lgr_bc_framer #(
  parameter integer FRAME_CYCLES = 120
) (
  input wire mclk_i,
  input wire sys_rst_i,
  output reg frame_stb_o
);
  reg [15:0] cnt_q;

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_q <= 16'h0000;
      frame_stb_o <= 1'b0;
    end else if (cnt_q == FRAME_CYCLES[15:0] - 16'h0001) begin
      cnt_q <= 16'h0000;
      frame_stb_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      frame_stb_o <= 1'b0;
    end
  end
endmodule // lgr_bc_framer
`default_nettype wire

// >>> rtl/lgr_pin_mux.v
// Output selector for one general-purpose pin.
// Assumes all source vectors are on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "lgr_map.vh"
module lgr_pin_mux (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [2:0] src_i,
  input wire [2:0] func_i,
  input wire level_i,
  input wire drive_i,
  input wire [7:0] rx0_i,
  input wire [7:0] rx1_i,
  input wire [6:0] dev_i,
  input wire [5:0] csi_i,
  output reg pin_o,
  output reg pin_oe_n_o
);
  reg bit_d;
  reg ok_d;

  always @* begin
    bit_d = 1'b0;
    ok_d = 1'b1;
    case (src_i)
      `LGR_SRC_RX0: bit_d = rx0_i[func_i];
      `LGR_SRC_RX1: bit_d = rx1_i[func_i];
      `LGR_SRC_DEV: begin
        if (func_i == 3'h0) begin
          bit_d = level_i;
        end else if (func_i == 3'h7) begin
          ok_d = 1'b0;
        end else begin
          bit_d = dev_i[func_i];
        end
      end
      `LGR_SRC_CSI: begin
        if (func_i[2:1] == 2'h3) begin
          ok_d = 1'b0;
        end else begin
          bit_d = csi_i[func_i];
        end
      end
      default: ok_d = 1'b0;
    endcase
  end

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else begin
      pin_o <= bit_d & ok_d & drive_i;
      pin_oe_n_o <= ~(drive_i & ok_d);
    end
  end
endmodule // lgr_pin_mux
`default_nettype wire

// >>> dv/lgr_ser_model.sv
// Remote serializer model: forward frame pulses and forwarded GPIO levels.
// Assumes the bench sets the GPIO levels and the frame spacing.
`timescale 1ns/1ps
`default_nettype none
module lgr_ser_model (
  input wire logic mclk_i,
  input wire logic [3:0] gpio_i,
  input wire logic [7:0] gap_i,
  output logic [1:0] frame_o,
  output logic [3:0] fwd0_o,
  output logic [3:0] fwd1_o
);
  logic [7:0] cnt_q = 8'h00;
  initial begin
    frame_o = 2'h0;
    fwd0_o = 4'h0;
    fwd1_o = 4'h0;
  end
  // Levels move only at frame starts, in the cycle of the frame pulse, so the router samples each level with its frame.
  always @(posedge mclk_i) begin
    cnt_q <= (cnt_q >= gap_i) ? 8'h00 : cnt_q + 8'h01;
    frame_o <= {2{cnt_q == 8'h00}};
    // Only the newer serializer type is modelled, since an older one forwards no GPIO.
    if (cnt_q == 8'h00) begin
      fwd0_o <= gpio_i;
      fwd1_o <= ~gpio_i;
    end
  end
endmodule // lgr_ser_model
`default_nettype wire

// >>> dv/lgr_top_sva.sv
// Checker of the GPIO router: reset state, pin 0 selection and back-channel framing.
// Assumes it is bound to lgr_top; pin 0 control is shadowed from bus writes.
`timescale 1ns/1ps
`default_nettype none
module lgr_top_sva #(
  parameter integer PINS = 7,
  parameter integer FRAME_CYCLES = 120
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire hsel_i,
  input wire [9:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire [PINS-1:0] gpio_pin_o,
  input wire [PINS-1:0] gpio_pin_oe_n_o,
  input wire dev_irq_i,
  input wire csi_fv_i,
  input wire rx_synced_i,
  input wire [3:0] bc_slot0_o,
  input wire [3:0] bc_slot1_o,
  input wire bc_frame_o
);
  // ****
  // Shadow state
  // ****
  reg wr_q;
  reg seen_q;
  reg [7:0] sh_q;
  reg [7:0] sh_p;
  reg [7:0] gap_q;
  // The pin follows a new control word one cycle late, so only a word held twice is judged.
  wire steady = sh_q == sh_p;
  wire rsv = sh_q[2:1] == 2'h1 || sh_q[2:1] == 2'h3 || sh_q[5:0] == 6'h3c || sh_q[5:4] == 2'h3 && sh_q[2:0] == 3'h5;
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_q <= 1'b0;
      seen_q <= 1'b0;
      sh_q <= 8'h00;
      sh_p <= 8'h00;
      gap_q <= 8'h00;
    end else begin
      wr_q <= hsel_i && htrans_i[1] && hready_i && hwrite_i && haddr_i == 10'h040;
      if (wr_q) begin
        sh_q <= hwdata_i[7:0];
      end
      sh_p <= sh_q;
      gap_q <= bc_frame_o ? 8'h00 : gap_q + 8'h01;
      if (bc_frame_o) begin
        seen_q <= 1'b1;
      end
    end
  end
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  reset_pins_a: assert property ($fell(sys_rst_i) |-> &gpio_pin_oe_n_o && gpio_pin_o == '0)
    else $error("pins driven after reset");
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or not okay");
  frame_gap_a: assert property (seen_q |-> gap_q < FRAME_CYCLES && (!bc_frame_o || gap_q == FRAME_CYCLES - 1))
    else $error("frame spacing wrong");
  slot_hold_a: assert property (!bc_frame_o |-> $stable({bc_slot0_o, bc_slot1_o}))
    else $error("slots moved between frames");
  drive_off_a: assert property (steady && !sh_q[7] |-> gpio_pin_oe_n_o[0])
    else $error("pin driven while disabled");
  irq_high_a: assert property (steady && sh_q == 8'hac |-> !gpio_pin_oe_n_o[0] && gpio_pin_o[0] == $past(dev_irq_i))
    else $error("interrupt high wrong");
  irq_low_a: assert property (steady && sh_q == 8'hb4 |-> !gpio_pin_oe_n_o[0] && gpio_pin_o[0] == !$past(dev_irq_i))
    else $error("interrupt low wrong");
  frame_valid_a: assert property (steady && sh_q == 8'h95 |-> gpio_pin_o[0] == $past(csi_fv_i))
    else $error("frame valid wrong");
  ports_synced_a: assert property (steady && sh_q == 8'ha5 |-> gpio_pin_o[0] == $past(rx_synced_i))
    else $error("synced flag wrong");
  reserved_off_a: assert property (steady && rsv |-> gpio_pin_oe_n_o[0] && !gpio_pin_o[0])
    else $error("reserved selection drives pin");
endmodule // lgr_top_sva
bind lgr_top lgr_top_sva #(.PINS(PINS), .FRAME_CYCLES(FRAME_CYCLES)) u_sva (.mclk_i, .sys_rst_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .gpio_pin_o, .gpio_pin_oe_n_o,
  .dev_irq_i, .csi_fv_i, .rx_synced_i, .bc_slot0_o, .bc_slot1_o, .bc_frame_o);
`default_nettype wire

// >>> dv/tb_link_gpio_router.sv
// Testbench of the GPIO router: registers, pin selection and back-channel slots.
// Assumes a 200 MHz clock and a back-channel frame shortened to 12 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_link_gpio_router;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [9:0] haddr_i = 10'h000;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [6:0] gpio_pin_i = 7'h00;
  logic [1:0] rx_lock_i = 2'h0;
  logic [1:0] rx_pass_i = 2'h0;
  logic [1:0] rx_fv_i = 2'h0;
  logic [1:0] rx_lv_i = 2'h0;
  logic csi_fv_i = 1'b0;
  logic csi_lv_i = 1'b0;
  logic rx_synced_i = 1'b0;
  logic dev_irq_i = 1'b0;
  logic csi_irq_i = 1'b0;
  logic frame_sync_pulse_i = 1'b0;
  logic efs = 1'b0;
  logic [2:0] pin_ix = 3'h0;
  logic [3:0] gp = 4'h0;
  logic pin_stb = 1'b0;
  logic rd_dp = 1'b0;
  logic [31:0] seed = 32'h09b6;
  wire [31:0] hrdata_o;
  wire hreadyout_o;
  wire hresp_o;
  wire [6:0] gpio_pin_o;
  wire [6:0] gpio_pin_oe_n_o;
  wire [3:0] fwd_gpio0_i;
  wire [3:0] fwd_gpio1_i;
  wire [1:0] fwd_frame_i;
  wire [3:0] bc_slot0_o;
  wire [3:0] bc_slot1_o;
  wire bc_frame_o;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] rd_q[$];
  logic [31:0] pin_q[$];
  logic [31:0] sl_q[$];
  // Pin 0 control word and expected {enable_n, level}; 3 leaves the check to the checker.
  logic [15:0] tbl[22] = '{16'h0402,
    16'h8400, 16'hc401, 16'h8c01, 16'h9400, 16'h9c00, 16'ha401,
    16'h8001, 16'h9901, 16'ha001, 16'ha100,
    16'h8500, 16'h8d01, 16'h9d01, 16'had01, 16'hb502,
    16'h8202, 16'hbc02, 16'hac03, 16'hb403, 16'h9503, 16'ha503};
  always #2.5 mclk_i = ~mclk_i;
  lgr_top #(.PINS(7), .FRAME_CYCLES(12)) uut (.mclk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .gpio_pin_i,
    .gpio_pin_o, .gpio_pin_oe_n_o, .fwd_gpio0_i, .fwd_gpio1_i, .fwd_frame_i, .rx_lock_i, .rx_pass_i,
    .rx_fv_i, .rx_lv_i, .csi_fv_i, .csi_lv_i, .rx_synced_i, .dev_irq_i, .csi_irq_i, .frame_sync_pulse_i,
    .ext_frame_sync_i(efs), .bc_slot0_o, .bc_slot1_o, .bc_frame_o);
  lgr_ser_model u_ser (.mclk_i, .gpio_i(gp), .gap_i(8'h08), .frame_o(fwd_frame_i), .fwd0_o(fwd_gpio0_i),
    .fwd1_o(fwd_gpio1_i));
  // ****
  // Tasks
  // ****
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task wt(input bit fr);
    int k;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while ((fr ? bc_frame_o : hreadyout_o) !== 1'b1 && k < 40);
    if ((fr ? bc_frame_o : hreadyout_o) !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {idx, 2'h0};
    hwrite_i <= w;
    wt(1'b0);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    wt(1'b0);
  endtask
  task rd(input logic [7:0] idx, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, idx, 8'h00);
  endtask
  task pin_chk(input logic [1:0] e);
    pin_q.push_back({30'h0, e});
    pin_stb <= 1'b1;
    @(posedge mclk_i);
    pin_stb <= 1'b0;
  endtask
  task do_rst;
    sys_rst_i <= 1'b1;
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  // ****
  // Stimulus and result watcher
  // ****
  always @(posedge mclk_i) begin
    seed <= xs(seed);
    {dev_irq_i, csi_fv_i, rx_synced_i, rx_fv_i, rx_lv_i} <= seed[6:0];
    if (rd_dp && rd_q.size() > 0) chk(hrdata_o, rd_q.pop_front());
    if (pin_stb && pin_q.size() > 0) chk({30'h0, gpio_pin_oe_n_o[pin_ix], gpio_pin_o[pin_ix]}, pin_q.pop_front());
    if (bc_frame_o && sl_q.size() > 0) chk({24'h0, bc_slot1_o, bc_slot0_o}, sl_q.pop_front());
    rd_dp <= hsel_i && htrans_i[1] && !hwrite_i && hreadyout_o;
  end
  initial begin
    logic [6:0] p;
    logic f;
    do_rst();
    rd(8'h10, 32'h00);
    rd(8'h18, 32'h06);
    rd(8'h6f, 32'h00);
    bus(1'b1, 8'h30, 8'hff);
    rd(8'h30, 32'h00);
    bus(1'b1, 8'h6e, 8'h31);
    bus(1'b1, 8'h6f, 8'h76);
    bus(1'b1, 8'h18, 8'h07);
    bus(1'b1, 8'h6e, 8'h22);
    bus(1'b1, 8'h6f, 8'h55);
    rd(8'h6e, 32'h22);
    bus(1'b1, 8'h18, 8'h06);
    rd(8'h6e, 32'h31);
    rd(8'h6f, 32'h76);
    $display("done: registers");
    for (int i = 0; i < 4; i++) begin
      p = seed[6:0];
      f = seed[7];
      gpio_pin_i <= p;
      frame_sync_pulse_i <= f;
      wt(1'b1);
      wt(1'b1);
      @(posedge mclk_i);
      sl_q.push_back({24'h0, p[5], p[5], p[2], p[2], f, p[6], p[3], p[1]});
      wt(1'b1);
    end
    rd(8'h1a, {25'h0, p});
    $display("done: slots");
    rx_lock_i <= 2'h1;
    rx_pass_i <= 2'h2;
    csi_lv_i <= 1'b1;
    csi_irq_i <= 1'b1;
    frame_sync_pulse_i <= 1'b1;
    gp <= 4'h5;
    foreach (tbl[i]) begin
      bus(1'b1, 8'h10, tbl[i][15:8]);
      repeat (12) @(posedge mclk_i);
      if (tbl[i][1:0] != 2'h3) begin
        pin_chk(tbl[i][1:0]);
      end
    end
    pin_ix <= 3'h6;
    bus(1'b1, 8'h16, 8'hc4);
    repeat (12) @(posedge mclk_i);
    pin_chk(2'h1);
    pin_ix <= 3'h0;
    efs <= 1'b1;
    frame_sync_pulse_i <= 1'b0;
    bus(1'b1, 8'h18, 8'h0e);
    bus(1'b1, 8'h10, 8'ha4);
    repeat (12) @(posedge mclk_i);
    pin_chk(2'h1);
    bus(1'b1, 8'h10, 8'h80);
    repeat (12) @(posedge mclk_i);
    pin_chk(2'h1);
    // Three linked GPIO: the new level may only show after the fifth forward frame.
    bus(1'b1, 8'h19, 8'h33);
    gp <= 4'h4;
    repeat (20) @(posedge mclk_i);
    pin_chk(2'h1);
    repeat (50) @(posedge mclk_i);
    pin_chk(2'h0);
    rd(8'h19, 32'h33);
    $display("done: pins");
    do_rst();
    rd(8'h10, 32'h00);
    rd(8'h18, 32'h06);
    $display("done: second reset");
    wrap_up();
  end
endmodule // tb_link_gpio_router
`default_nettype wire
